// >>> dv/swl_cfg_chk_sva.sv
// assertion checker for the link configuration block ports
`timescale 1ns/1ps
module swl_cfg_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [swl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // configuration outputs
  input wire logic [swl_pkg::NUM_XLINK-1:0] xl_enable,
  input wire logic [swl_pkg::NUM_XLINK-1:0] xl_five_wire,
  input wire logic [swl_pkg::NUM_XLINK-1:0] xl_startup_send,
  input wire logic [swl_pkg::NUM_XLINK-1:0] xl_rx_reset,
  input wire logic [swl_pkg::NUM_XLINK-1:0][swl_pkg::GAP_W-1:0] xl_token_gap,
  input wire logic [swl_pkg::NUM_XLINK-1:0] st_bypass,
  input wire logic [swl_pkg::NUM_XLINK-1:0][swl_pkg::CE_W-1:0] st_chanend,
  input wire logic [swl_pkg::NUM_PLINK-1:0][1:0] pl_network
);
  // one clock domain, reset disables everything
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // write strobe at one byte address
  sequence s_wr(logic [11:0] a);
    reg_wr && reg_addr == a;
  endsequence
  // startup pulse of link c, exactly one cycle
  sequence s_pulse_c;
    xl_startup_send[2] ##1 !xl_startup_send[2];
  endsequence
  // receiver reset pulse of link a, exactly one cycle
  sequence s_pulse_a;
    xl_rx_reset[0] ##1 !xl_rx_reset[0];
  endsequence
  a_startup_pulse: assert property (s_wr(12'h200) ##0 reg_wdata[24] |=> s_pulse_c)
    else $error("startup pulse missing on link c");
  a_startup_cause: assert property (xl_startup_send != 0
    |-> $past(reg_wr) && $past(reg_wdata[24]))
    else $error("startup pulse without init write");
  a_rxreset_pulse: assert property (s_wr(12'h20c) ##0 reg_wdata[23] |=> s_pulse_a)
    else $error("receiver reset pulse wrong on link a");
  a_enable_slot: assert property (s_wr(12'h204) |=> xl_enable[3] == $past(reg_wdata[31]))
    else $error("enable of link d not taken from slot 1");
  a_width_slot: assert property (s_wr(12'h210) |=> xl_five_wire[6] == $past(reg_wdata[30]))
    else $error("width of link g not taken from slot 4");
  a_token_gap: assert property (s_wr(12'h21c)
    |=> xl_token_gap[5] == $past(reg_wdata[10:0]))
    else $error("token gap of link f not taken from slot 7");
  a_static_hold: assert property (!reg_wr |=> $stable(st_bypass) && $stable(st_chanend))
    else $error("static config changed without a write");
  a_static_write: assert property (s_wr(12'h288) |=> st_bypass[1] == $past(reg_wdata[31])
    && st_chanend[1] == $past(reg_wdata[4:0]))
    else $error("static config of link b not taken from slot 2");
  a_net_write: assert property (s_wr(12'h104) |=> pl_network[1] == $past(reg_wdata[5:4]))
    else $error("network of processor link 1 not taken");
endmodule

// >>> dv/swl_far_end.sv
// far-end switch model: answers each startup token with credit
`timescale 1ns/1ps
module swl_far_end #(
  parameter int BASE_DLY = 2  // reply delay of link a; later links answer slower
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // startup tokens from the local links
  input wire logic [7:0] startup_send,
  // credit state back to the local links
  output logic [7:0] credit_grant,
  output logic [7:0] credit_issued
);
  int cnt [8];  // cycles left until credit returns, 0 when idle
  // per-link reply timer, grant is a one-cycle pulse
  always_ff @(posedge core_clk or negedge nrst) begin
    for (int i = 0; i < 8; i++) begin
      credit_grant[i] <= 1'b0;
      if (!nrst) begin
        cnt[i] <= 0;
        credit_issued[i] <= 1'b0;
      end else if (startup_send[i]) begin
        cnt[i] <= BASE_DLY + 2 * i;
        credit_issued[i] <= 1'b1;
      end else if (cnt[i] == 1) begin
        cnt[i] <= 0;
        credit_grant[i] <= 1'b1;
      end else if (cnt[i] > 1) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
endmodule

// >>> dv/tb.sv
// self-checking bench for the link configuration block
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0][1:0] pl_type = '0;
  logic [3:0][7:0] pl_dest = '0;
  logic [3:0] pl_junk = 4'h0;
  logic [3:0] pl_route_out = 4'h0;
  logic [3:0] pl_route_in = 4'h0;
  logic [3:0][1:0] pl_network;
  logic [7:0] xl_rx_overflow = 8'h0;
  logic [7:0] xl_bad_token = 8'h0;
  logic [7:0] xl_credit_issued, xl_credit_grant, xl_enable, xl_five_wire;
  logic [7:0] xl_startup_send, xl_rx_reset, st_bypass;
  logic [7:0][10:0] xl_trans_gap, xl_token_gap;
  logic [7:0][4:0] st_chanend;
  int error_cnt = 0;
  int n_checks = 0;
  int ord [8] = '{2, 3, 1, 0, 6, 7, 4, 5};  // slot to link letter, a=0
  // ------------------------------------------------------------
  // design and far end
  // ------------------------------------------------------------
  swl_cfg_top swl_cfg_top_i (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pl_type(pl_type), .pl_dest(pl_dest), .pl_junk(pl_junk), .pl_route_out(pl_route_out),
    .pl_route_in(pl_route_in), .pl_network(pl_network), .xl_rx_overflow(xl_rx_overflow),
    .xl_bad_token(xl_bad_token), .xl_credit_issued(xl_credit_issued),
    .xl_credit_grant(xl_credit_grant), .xl_enable(xl_enable), .xl_five_wire(xl_five_wire),
    .xl_startup_send(xl_startup_send), .xl_rx_reset(xl_rx_reset),
    .xl_trans_gap(xl_trans_gap), .xl_token_gap(xl_token_gap), .st_bypass(st_bypass),
    .st_chanend(st_chanend));
  swl_far_end swl_far_end_i (.core_clk(core_clk), .nrst(nrst), .startup_send(xl_startup_send),
    .credit_grant(xl_credit_grant), .credit_issued(xl_credit_issued));
  // free-running 100 MHz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  // compare and count
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one-cycle write
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic rd(string nm, logic [11:0] a, logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask
  // one-cycle fault events
  task automatic ev(logic [7:0] ov, logic [7:0] bt);
    @(posedge core_clk);
    xl_rx_overflow <= ov;
    xl_bad_token <= bt;
    @(posedge core_clk);
    xl_rx_overflow <= 8'h0;
    xl_bad_token <= 8'h0;
  endtask
  // counts and verdict, then stop
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    complete_run;
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    int i;
    int o;
    logic [31:0] d;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd("xl rst", 12'h200, 32'h0);
    rd("st rst", 12'h280, 32'h0);
    rd("pl rst", 12'h100, 32'h0);
    $display("test reset done");
    ev(8'h08, 8'h40);
    rd("err d", 12'h204, 32'h0800_0000);
    rd("err d clr", 12'h204, 32'h0);
    rd("err g", 12'h210, 32'h0800_0000);
    $display("test error done");
    @(posedge core_clk);
    for (i = 0; i < 4; i++) begin
      pl_type[i] <= 2'(i % 3);
      pl_dest[i] <= 8'(17 * (i + 1));
    end
    pl_junk <= 4'h2;
    pl_route_out <= 4'h4;
    pl_route_in <= 4'hf;
    for (i = 0; i < 4; i++) begin
      wr(12'(256 + 4 * i), 32'hffff_ffcf | 32'(i << 4));
      chk("pl net", 32'(i), 32'(pl_network[i]));
      d = {6'h0, 2'(i % 3), 8'(17 * (i + 1)), 10'h0, 2'(i), 1'b0, 1'(i == 1), 1'(i == 2), 1'b1};
      rd("pl word", 12'(256 + 4 * i), d);
    end
    @(posedge core_clk);
    pl_route_in <= 4'h0;
    rd("pl idle", 12'h104, 32'h14);
    $display("test plink done");
    for (i = 0; i < 8; i++) begin
      o = ord[i];
      wr(12'(640 + 4 * i), 32'hffff_fff0 | 32'(i));
      chk("st out", 32'(48 + i), {26'h0, st_bypass[o], st_chanend[o]});
      rd("st rd", 12'(640 + 4 * i), 32'h8000_0010 | 32'(i));
    end
    $display("test static done");
    for (i = 0; i < 8; i++) begin
      o = ord[i];
      d = 32'h8000_0000 | 32'(i % 2) << 30 | 32'(2047 - i) << 11 | 32'(1024 + i);
      wr(12'(512 + 4 * i), d | 32'h3040_0000);
      chk("xl mode", 32'(2 + i % 2), {30'h0, xl_enable[o], xl_five_wire[o]});
      chk("xl gaps", {10'h0, d[21:0]}, {10'h0, xl_trans_gap[o], xl_token_gap[o]});
      rd("xl rd", 12'(512 + 4 * i), d);
    end
    wr(12'h204, 32'h0);
    chk("xl off", 32'h0, 32'(xl_enable[3]));
    $display("test xlink done");
    wr(12'h200, 32'h8100_0000);
    chk("startup", 32'h4, 32'(xl_startup_send));
    tick;
    chk("startup end", 32'h0, 32'(xl_startup_send));
    for (i = 0; i < 30 && xl_credit_grant[2] !== 1'b1; i++) begin
      tick;
    end
    // a missing grant counts once; the remaining tests still run to the report
    if (i == 30) begin
      error_cnt++;
      $display("BAD credit wait exp grant got none");
    end
    rd("credit", 12'h200, 32'h8600_0000);
    wr(12'h200, 32'h8100_0000);
    rd("credit clr", 12'h200, 32'h8400_0000);
    wr(12'h20c, 32'h0080_0000);
    chk("rx rst", 32'h1, 32'(xl_rx_reset));
    tick;
    chk("rx rst end", 32'h0, 32'(xl_rx_reset));
    $display("test init done");
    wr(12'h300, 32'hffff_ffff);
    rd("unmapped", 12'h300, 32'h0);
    rd("misalign", 12'h202, 32'h0);
    $display("test refuse done");
    complete_run;
  end
endmodule

// checker on the top module ports
bind swl_cfg_top swl_cfg_chk swl_cfg_chk_i (.core_clk(core_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .xl_enable(xl_enable),
  .xl_five_wire(xl_five_wire), .xl_startup_send(xl_startup_send), .xl_rx_reset(xl_rx_reset),
  .xl_token_gap(xl_token_gap), .st_bypass(st_bypass), .st_chanend(st_chanend),
  .pl_network(pl_network));

// >>> verilog/swl_cfg_top.sv
// register decoder and link configuration of the node switch
`timescale 1ns/1ps

module swl_cfg_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [swl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // processor link status from the switch
  input wire logic [swl_pkg::NUM_PLINK-1:0][1:0] pl_type,
  input wire logic [swl_pkg::NUM_PLINK-1:0][swl_pkg::DEST_W-1:0] pl_dest,
  input wire logic [swl_pkg::NUM_PLINK-1:0] pl_junk,
  input wire logic [swl_pkg::NUM_PLINK-1:0] pl_route_out,
  input wire logic [swl_pkg::NUM_PLINK-1:0] pl_route_in,
  // processor link network to the switch
  output logic [swl_pkg::NUM_PLINK-1:0][1:0] pl_network,
  // external link events, indexed by link letter a=0 .. h=7
  input wire logic [swl_pkg::NUM_XLINK-1:0] xl_rx_overflow,
  input wire logic [swl_pkg::NUM_XLINK-1:0] xl_bad_token,
  input wire logic [swl_pkg::NUM_XLINK-1:0] xl_credit_issued,
  input wire logic [swl_pkg::NUM_XLINK-1:0] xl_credit_grant,
  // external link configuration, indexed by link letter
  output logic [swl_pkg::NUM_XLINK-1:0] xl_enable,
  output logic [swl_pkg::NUM_XLINK-1:0] xl_five_wire,
  output logic [swl_pkg::NUM_XLINK-1:0] xl_startup_send,
  output logic [swl_pkg::NUM_XLINK-1:0] xl_rx_reset,
  output logic [swl_pkg::NUM_XLINK-1:0][swl_pkg::GAP_W-1:0] xl_trans_gap,
  output logic [swl_pkg::NUM_XLINK-1:0][swl_pkg::GAP_W-1:0] xl_token_gap,
  // static forwarding, indexed by link letter
  output logic [swl_pkg::NUM_XLINK-1:0] st_bypass,
  output logic [swl_pkg::NUM_XLINK-1:0][swl_pkg::CE_W-1:0] st_chanend
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  swl_pkg::swl_top_st_t s_r;    // registered state
  swl_pkg::swl_top_st_t s_nxt;  // next state

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [7:0] idx;          // register index
  logic addr_ok;            // word aligned and inside the index range
  logic sel_pl;             // processor link group hit
  logic sel_xl;             // external link group hit
  logic sel_st;             // static forwarding group hit
  logic [1:0] pl_slot;      // processor link number
  logic [2:0] xl_slot;      // slot within an eight-register group

  // index is the byte address divided by four
  assign idx = reg_addr[9:2];
  // low bits and the top bits must be zero for a hit
  assign addr_ok = (reg_addr[1:0] == 2'h0) && (reg_addr[swl_pkg::ADDR_W-1:10] == 2'h0);
  // group hits compare the upper index bits with the base
  assign sel_pl = addr_ok && (idx[7:2] == swl_pkg::IDX_PLINK_BASE[7:2]);
  assign sel_xl = addr_ok && (idx[7:3] == swl_pkg::IDX_XLINK_BASE[7:3]);
  assign sel_st = addr_ok && (idx[7:3] == swl_pkg::IDX_STATIC_BASE[7:3]);
  // slot within the group
  assign pl_slot = idx[1:0];
  assign xl_slot = idx[2:0];

  // ------------------------------------------------------------
  // processor link register images
  // ------------------------------------------------------------
  logic [swl_pkg::NUM_PLINK-1:0][31:0] pl_word;  // read image per processor link

  // type and destination only mean something while routing in,
  // so they read zero otherwise
  always_comb begin
    pl_word = '0;
    for (int i = 0; i < swl_pkg::NUM_PLINK; i++) begin
      // link type of the route target
      if (pl_route_in[i]) begin
        pl_word[i][swl_pkg::PL_TYPE_LSB +: 2] = pl_type[i];
        // destination link number
        pl_word[i][swl_pkg::PL_DEST_LSB +: swl_pkg::DEST_W] = pl_dest[i];
      end
      // network number from our own register
      pl_word[i][swl_pkg::PL_NET_LSB +: 2] = s_r.pl_net[i];
      // live status flags from the switch
      pl_word[i][swl_pkg::PL_JUNK_BIT] = pl_junk[i];
      pl_word[i][swl_pkg::PL_ROUT_BIT] = pl_route_out[i];
      pl_word[i][swl_pkg::PL_RIN_BIT] = pl_route_in[i];
    end
  end

  // ------------------------------------------------------------
  // static forwarding register images
  // ------------------------------------------------------------
  logic [swl_pkg::NUM_XLINK-1:0][31:0] st_word;  // read image per slot

  // reserved bits read zero
  always_comb begin
    st_word = '0;
    for (int i = 0; i < swl_pkg::NUM_XLINK; i++) begin
      st_word[i][swl_pkg::ST_EN_BIT] = s_r.st_en[i];
      st_word[i][swl_pkg::ST_CE_LSB +: swl_pkg::CE_W] = s_r.st_ce[i];
    end
  end

  // ------------------------------------------------------------
  // external link slots
  // ------------------------------------------------------------
  logic [swl_pkg::NUM_XLINK-1:0][31:0] xl_word;  // read image per slot

  swl_xl_if xl_bus [swl_pkg::NUM_XLINK] ();  // one carrier per slot

  // one link controller per slot, wired to its link letter
  for (genvar g = 0; g < swl_pkg::NUM_XLINK; g++) begin : g_xl
    // link letter driven by this slot
    localparam int LNK = int'(swl_pkg::XLINK_ORDER[g]);

    // strobes reach only the addressed slot
    assign xl_bus[g].wr = reg_wr && sel_xl && (xl_slot == 3'(g));
    assign xl_bus[g].rd = reg_rd && sel_xl && (xl_slot == 3'(g));
    assign xl_bus[g].wdata = reg_wdata;
    // collect the image for the read mux
    assign xl_word[g] = xl_bus[g].word;

    swl_xlink u_xl (
      .core_clk(core_clk),
      .nrst(nrst),
      .bus(xl_bus[g]),
      .rx_overflow(xl_rx_overflow[LNK]),
      .rx_bad_token(xl_bad_token[LNK]),
      .credit_issued(xl_credit_issued[LNK]),
      .credit_grant(xl_credit_grant[LNK]),
      .enable(xl_enable[LNK]),
      .five_wire(xl_five_wire[LNK]),
      .startup_send(xl_startup_send[LNK]),
      .rx_reset(xl_rx_reset[LNK]),
      .trans_gap(xl_trans_gap[LNK]),
      .token_gap(xl_token_gap[LNK])
    );

    // static forwarding of the same slot goes to the same letter
    assign st_bypass[LNK] = s_r.st_en[g];
    assign st_chanend[LNK] = s_r.st_ce[g];
  end

  // ------------------------------------------------------------
  // next state: register writes and read data
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // read data stand for one cycle only
    s_nxt.rdata = '0;

    // writes to local registers
    if (reg_wr) begin
      // processor link network number
      if (sel_pl) begin
        s_nxt.pl_net[pl_slot] = reg_wdata[swl_pkg::PL_NET_LSB +: 2];
      end
      // static forwarding enable and destination
      if (sel_st) begin
        s_nxt.st_en[xl_slot] = reg_wdata[swl_pkg::ST_EN_BIT];
        s_nxt.st_ce[xl_slot] = reg_wdata[swl_pkg::ST_CE_LSB +: swl_pkg::CE_W];
      end
    end

    // read mux, unmapped indices return zero
    if (reg_rd) begin
      if (sel_pl) begin
        s_nxt.rdata = pl_word[pl_slot];
      end else if (sel_xl) begin
        s_nxt.rdata = xl_word[xl_slot];
      end else if (sel_st) begin
        s_nxt.rdata = st_word[xl_slot];
      end else begin
        s_nxt.rdata = '0;
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= swl_pkg::TOP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // read data from the register stage
  assign reg_rdata = s_r.rdata;
  // network numbers to the switch arbiter
  assign pl_network = s_r.pl_net;

endmodule

// >>> verilog/swl_pkg.sv
// constants, register layout and state types of the link configuration block
package swl_pkg;

  // ------------------------------------------------------------
  // link counts and bus widths
  // ------------------------------------------------------------
  localparam int NUM_PLINK = 4;   // processor links
  localparam int NUM_XLINK = 8;   // external links
  localparam int ADDR_W = 12;     // byte address width
  localparam int GAP_W = 11;      // spacing field width
  localparam int CE_W = 5;        // channel end number width
  localparam int DEST_W = 8;      // destination link number width

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_PLINK_BASE = 8'h40;  // 0x40 .. 0x43
  localparam logic [7:0] IDX_XLINK_BASE = 8'h80;  // 0x80 .. 0x87
  localparam logic [7:0] IDX_STATIC_BASE = 8'ha0; // 0xa0 .. 0xa7

  // ------------------------------------------------------------
  // processor link status and network fields
  // ------------------------------------------------------------
  localparam int PL_TYPE_LSB = 24;
  localparam int PL_DEST_LSB = 16;
  localparam int PL_NET_LSB = 4;
  localparam int PL_JUNK_BIT = 2;
  localparam int PL_ROUT_BIT = 1;
  localparam int PL_RIN_BIT = 0;

  // ------------------------------------------------------------
  // external link configuration fields
  // ------------------------------------------------------------
  localparam int XL_EN_BIT = 31;
  localparam int XL_WIDE_BIT = 30;
  localparam int XL_ERR_BIT = 27;
  localparam int XL_CRI_BIT = 26;
  localparam int XL_CRH_BIT = 25;
  localparam int XL_INIT_BIT = 24;
  localparam int XL_RXR_BIT = 23;
  localparam int XL_TRG_LSB = 11;
  localparam int XL_TOK_LSB = 0;

  // ------------------------------------------------------------
  // static forwarding fields
  // ------------------------------------------------------------
  localparam int ST_EN_BIT = 31;
  localparam int ST_CE_LSB = 0;

  // register slot order: slot 0..7 drives links C,D,B,A,G,H,E,F (A=0 .. H=7)
  localparam logic [7:0][2:0] XLINK_ORDER = {3'h5, 3'h4, 3'h7, 3'h6,
                                             3'h0, 3'h1, 3'h3, 3'h2};

  // ------------------------------------------------------------
  // state types and reset values
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PLINK-1:0][1:0] pl_net;
    logic [NUM_XLINK-1:0] st_en;
    logic [NUM_XLINK-1:0][CE_W-1:0] st_ce;
    logic [31:0] rdata;
  } swl_top_st_t;

  typedef struct packed {
    logic en;
    logic wide;
    logic err;
    logic credit_held;
    logic init_p;
    logic rxrst_p;
    logic [GAP_W-1:0] trans_gap;
    logic [GAP_W-1:0] token_gap;
  } swl_xl_st_t;

  localparam swl_top_st_t TOP_RST = '0;  // every field clears
  localparam swl_xl_st_t XL_RST = '0;    // disabled, two-wire, no credit

endpackage

// >>> verilog/swl_xl_if.sv
// register access carrier between the decoder and one external link slot
`timescale 1ns/1ps
interface swl_xl_if;
  logic wr;            // write strobe for this slot
  logic rd;            // read strobe for this slot
  logic [31:0] wdata;  // write data
  logic [31:0] word;   // current register image

  modport reg_side (output wr, output rd, output wdata, input word);
  modport link_side (input wr, input rd, input wdata, output word);
endinterface

// >>> verilog/swl_xlink.sv
// configuration, error and credit state of one external link
`timescale 1ns/1ps
module swl_xlink (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register access
  swl_xl_if.link_side bus,
  // receiver and credit events
  input wire logic rx_overflow,
  input wire logic rx_bad_token,
  input wire logic credit_issued,
  input wire logic credit_grant,
  // configuration towards the link
  output logic enable,
  output logic five_wire,
  output logic startup_send,
  output logic rx_reset,
  output logic [swl_pkg::GAP_W-1:0] trans_gap,
  output logic [swl_pkg::GAP_W-1:0] token_gap
);

  swl_pkg::swl_xl_st_t s_r;    // registered state
  swl_pkg::swl_xl_st_t s_nxt;  // next state

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.init_p = 1'b0;   // pulses last one cycle
    s_nxt.rxrst_p = 1'b0;
    if (bus.wr) begin
      s_nxt.en = bus.wdata[swl_pkg::XL_EN_BIT];
      s_nxt.wide = bus.wdata[swl_pkg::XL_WIDE_BIT];
      s_nxt.trans_gap = bus.wdata[swl_pkg::XL_TRG_LSB +: swl_pkg::GAP_W];
      s_nxt.token_gap = bus.wdata[swl_pkg::XL_TOK_LSB +: swl_pkg::GAP_W];
      s_nxt.init_p = bus.wdata[swl_pkg::XL_INIT_BIT];
      s_nxt.rxrst_p = bus.wdata[swl_pkg::XL_RXR_BIT];
      // init drops our own credit
      if (bus.wdata[swl_pkg::XL_INIT_BIT]) begin
        s_nxt.credit_held = 1'b0;
      end
    end
    // returned credit wins over a clear in the same cycle
    if (credit_grant) begin
      s_nxt.credit_held = 1'b1;
    end
    // read clears the error, a new error in that cycle wins
    if (bus.rd) begin
      s_nxt.err = 1'b0;
    end
    if (rx_overflow || rx_bad_token) begin
      s_nxt.err = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= swl_pkg::XL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // register image, write-only bits read zero
  // ------------------------------------------------------------
  always_comb begin
    bus.word = '0;
    bus.word[swl_pkg::XL_EN_BIT] = s_r.en;
    bus.word[swl_pkg::XL_WIDE_BIT] = s_r.wide;
    bus.word[swl_pkg::XL_ERR_BIT] = s_r.err;
    bus.word[swl_pkg::XL_CRI_BIT] = credit_issued;
    bus.word[swl_pkg::XL_CRH_BIT] = s_r.credit_held;
    bus.word[swl_pkg::XL_TRG_LSB +: swl_pkg::GAP_W] = s_r.trans_gap;
    bus.word[swl_pkg::XL_TOK_LSB +: swl_pkg::GAP_W] = s_r.token_gap;
  end

  // outputs straight from flops
  assign enable = s_r.en;
  assign five_wire = s_r.wide;
  assign startup_send = s_r.init_p;
  assign rx_reset = s_r.rxrst_p;
  assign trans_gap = s_r.trans_gap;
  assign token_gap = s_r.token_gap;

endmodule
